// ==== rtl/trr_pkg.sv ====
// Purpose: Shared constants and types for the temperature result register
// Assumes: One system clock; conversion logic on the same clock
// Notes:   Field positions and reset values live here only
package trr_pkg;

    // Register and field widths
    localparam int RESULT_W   = 16;
    localparam int BYTE_W     = 8;
    localparam int RAW_W      = 13;
    localparam int NORM_W     = 12;
    localparam int PTR_W      = 8;

    // Temperature field placement, left-justified
    localparam int NORM_LSB   = 4;
    localparam int EXT_LSB    = 3;
    localparam int FMT_BIT    = 0;
    localparam int HI_LSB     = 8;

    // Pointer value that selects the temperature result
    localparam logic [PTR_W-1:0] PTR_TEMP = 8'h00;

    // Reset and fixed values
    localparam logic [RESULT_W-1:0] RESULT_RST  = 16'h0000;
    localparam logic [BYTE_W-1:0]   BYTE_IDLE   = 8'h00;
    localparam logic [NORM_W-1:0]   NORM_POSMAX = 12'h07ff;
    localparam logic [NORM_W-1:0]   NORM_NEGMAX = 12'h0800;
    localparam logic [2:0]          NORM_PAD    = 3'h0;
    localparam logic [1:0]          EXT_PAD     = 2'h0;

    // Scale of one field step, in millidegrees times ten
    localparam int LSB_TENTH_MDEG = 625;

    // Result of one conversion, from the converter
    typedef struct packed {
        logic                    done;
        logic signed [RAW_W-1:0] raw;
    } trr_conv_t;

    // Requests from the two-wire protocol engine
    typedef struct packed {
        logic             ptr_wr;
        logic [PTR_W-1:0] ptr_val;
        logic             rd_start;
        logic             byte_req;
        logic             xfer_end;
    } trr_bus_req_t;

    // Read sequencer states
    typedef enum logic [1:0] {
        TRR_IDLE,
        TRR_HIGH,
        TRR_LOW,
        TRR_DONE
    } trr_state_t;

endpackage

// ==== rtl/trr_result.sv ====
// Purpose: Temperature result register with two-byte read sequencer
// Assumes: Converter and protocol engine run on i_sys_clk
// Notes:   Read data is a snapshot taken at read start
`timescale 1ns/10ps
// What this block does
// - Each finished conversion is written into the result register.
// - The held value is 12 bits in normal format and 13 in extended.
// - A read returns the high byte first and then the low byte.
// - The field is left-justified in the top 12 or 13 bits.
// - A read may stop after the high byte with no error.
// - One field step stands for 0.0625 degrees in both formats.
// - Readings below zero are two's complement with the top bit set.
// - From reset to the first conversion the register reads zero.
// - Bit 0 of the low byte shows the format select setting.
// - All other bits of the register read as zero.
// - A read returns the register chosen by the last pointer write.
// - A nack or stop ends the read and data drive stops; a start restarts it, or ends it if another pointer is set.
module trr_result
    import trr_pkg::*;
(
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_n,
    input  wire trr_conv_t           i_conv,
    input  wire logic                i_extended_format_select,
    input  wire trr_bus_req_t        i_bus,
    output logic [RESULT_W-1:0]      o_temp_result,
    output logic [BYTE_W-1:0]        o_rd_byte,
    output logic                     o_byte_valid,
    output logic                     o_data_drive,
    output logic                     o_temp_sel,
    output logic                     o_conv_seen
);

    logic [RESULT_W-1:0] result_reg;
    logic [RESULT_W-1:0] result_next;
    logic [RESULT_W-1:0] shadow_reg;
    logic [RESULT_W-1:0] shadow_next;
    logic [PTR_W-1:0]    ptr_reg;
    logic [PTR_W-1:0]    ptr_next;
    trr_state_t          state_reg;
    trr_state_t          state_next;
    logic [BYTE_W-1:0]   byte_reg;
    logic [BYTE_W-1:0]   byte_next;
    logic                valid_reg;
    logic                valid_next;
    logic                drive_reg;
    logic                drive_next;
    logic                seen_reg;
    logic                seen_next;

    wire logic              ovf12;
    wire logic [NORM_W-1:0] sat12;
    wire logic [NORM_W-1:0] val12;
    wire logic [RESULT_W-1:0] norm_word;
    wire logic [RESULT_W-1:0] ext_word;
    wire logic [RESULT_W-1:0] fmt_word;
    wire logic              sel_temp;
    wire logic              start_ok;
    wire logic              take_byte;

    // Normal format clamps: the 12-bit field cannot hold 128 degrees
    // normal range clamp
    assign ovf12 = i_conv.raw[RAW_W-1] ^ i_conv.raw[NORM_W-1];
    assign sat12 = i_conv.raw[RAW_W-1] ? NORM_NEGMAX : NORM_POSMAX;
    assign val12 = ovf12 ? sat12 : i_conv.raw[NORM_W-1:0];

    // raw step kept as field step
    assign norm_word = {val12, NORM_PAD, 1'b0};
    assign ext_word  = {i_conv.raw, EXT_PAD, 1'b1};
    assign fmt_word  = i_extended_format_select ? ext_word : norm_word;

    // Pointer decode and read control
    // pointer picks register
    assign sel_temp  = (ptr_reg == PTR_TEMP);
    assign start_ok  = i_bus.rd_start & sel_temp;
    assign take_byte = i_bus.byte_req & ~i_bus.xfer_end;

    // Result capture; whole word at once so no torn value is stored
    // store every conversion
    assign result_next = i_conv.done ? fmt_word : result_reg;
    assign seen_next   = seen_reg | i_conv.done;
    assign ptr_next    = i_bus.ptr_wr ? i_bus.ptr_val : ptr_reg;

    assign shadow_next = start_ok ? result_reg : shadow_reg;

    // Read sequencer; a new start also restarts a read in flight
    always_comb begin
        state_next = state_reg;
        byte_next  = byte_reg;
        valid_next = 1'b0;
        drive_next = drive_reg;
        if (i_bus.xfer_end) begin
            state_next = TRR_IDLE;
            drive_next = 1'b0;
            byte_next  = BYTE_IDLE;
        end else if (start_ok) begin
            state_next = TRR_HIGH;
            drive_next = 1'b1;
        end else if (i_bus.rd_start) begin
            // Other pointer: another block answers
            state_next = TRR_IDLE;
            drive_next = 1'b0;
        end else begin
            case (state_reg)
                TRR_IDLE: begin
                    drive_next = 1'b0;
                end
                TRR_HIGH: begin
                    if (take_byte) begin
                        byte_next  = shadow_reg[RESULT_W-1:HI_LSB];
                        valid_next = 1'b1;
                        state_next = TRR_LOW;
                    end
                end
                TRR_LOW: begin
                    if (take_byte) begin
                        byte_next  = shadow_reg[HI_LSB-1:0];
                        valid_next = 1'b1;
                        state_next = TRR_DONE;
                    end
                end
                TRR_DONE: begin
                    // Extra byte requests get nothing
                    drive_next = 1'b0;
                end
                default: begin
                    state_next = TRR_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    // Result and pointer storage
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_reg <= RESULT_RST;
            shadow_reg <= RESULT_RST;
            ptr_reg    <= PTR_TEMP;
            seen_reg   <= 1'b0;
        end else begin
            result_reg <= result_next;
            shadow_reg <= shadow_next;
            ptr_reg    <= ptr_next;
            seen_reg   <= seen_next;
        end
    end

    // Sequencer registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= TRR_IDLE;
            byte_reg  <= BYTE_IDLE;
            valid_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            byte_reg  <= byte_next;
            valid_reg <= valid_next;
            drive_reg <= drive_next;
        end
    end

    // Select flag registered so every output is a flop
    logic sel_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_reg <= 1'b1;
        end else begin
            sel_reg <= (ptr_next == PTR_TEMP);
        end
    end

    // Outputs
    assign o_temp_result = result_reg;
    assign o_rd_byte     = byte_reg;
    assign o_byte_valid  = valid_reg;
    assign o_data_drive  = drive_reg;
    assign o_temp_sel    = sel_reg;
    assign o_conv_seen   = seen_reg;

    // Checks on stored value and on read sequencing
    property p_store;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_conv.done |=> result_reg == $past(fmt_word);
    endproperty
    a_store: assert property (p_store)
        else $error("result not stored after conversion");

    property p_width;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_conv.done && !i_extended_format_select && !ovf12)
        |=> $signed(result_reg[RESULT_W-1:NORM_LSB])
            == $signed($past(i_conv.raw[NORM_W-1:0]));
    endproperty
    a_width: assert property (p_width)
        else $error("normal field does not match conversion");

    property p_just;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !result_reg[FMT_BIT] |-> result_reg[NORM_LSB-1:FMT_BIT+1] == NORM_PAD;
    endproperty
    a_just: assert property (p_just)
        else $error("normal field not left-justified");

    property p_step;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_conv.done && i_extended_format_select)
        |=> result_reg[RESULT_W-1:EXT_LSB] == $past(i_conv.raw);
    endproperty
    a_step: assert property (p_step)
        else $error("extended field step differs from raw");

    property p_sign;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_conv.done |=> result_reg[RESULT_W-1] == $past(i_conv.raw[RAW_W-1]);
    endproperty
    a_sign: assert property (p_sign)
        else $error("sign bit wrong");

    property p_zero;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !seen_reg |-> result_reg == RESULT_RST;
    endproperty
    a_zero: assert property (p_zero)
        else $error("nonzero result before first conversion");

    property p_flag;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_conv.done |=> result_reg[FMT_BIT] == $past(i_extended_format_select);
    endproperty
    a_flag: assert property (p_flag)
        else $error("format indicator wrong");

    property p_unused;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        result_reg[EXT_LSB-1:FMT_BIT+1] == EXT_PAD;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bits not zero");

    property p_order;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == TRR_HIGH && take_byte && !i_bus.rd_start)
        |=> valid_reg && state_reg == TRR_LOW
            && byte_reg == shadow_reg[RESULT_W-1:HI_LSB];
    endproperty
    a_order: assert property (p_order)
        else $error("high byte not sent first");

    property p_low;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == TRR_LOW && take_byte && !i_bus.rd_start)
        |=> valid_reg && byte_reg == shadow_reg[HI_LSB-1:0];
    endproperty
    a_low: assert property (p_low)
        else $error("low byte not sent second");

    property p_drive;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (start_ok && !i_bus.xfer_end) |=> drive_reg && state_reg == TRR_HIGH;
    endproperty
    a_drive: assert property (p_drive)
        else $error("selected read not served");

    property p_short;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == TRR_LOW && i_bus.xfer_end)
        |=> state_reg == TRR_IDLE ##1 !drive_reg;
    endproperty
    a_short: assert property (p_short)
        else $error("shortened read not accepted");

    property p_ptr;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.rd_start && !sel_temp && !i_bus.xfer_end)
        |=> !drive_reg && state_reg == TRR_IDLE;
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("read served for other pointer");

    property p_end;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_bus.xfer_end |=> !drive_reg && !valid_reg;
    endproperty
    a_end: assert property (p_end)
        else $error("data still driven after end");

    property p_atomic;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg != TRR_IDLE && !start_ok) |=> $stable(shadow_reg);
    endproperty
    a_atomic: assert property (p_atomic)
        else $error("snapshot changed inside a read");

endmodule // trr_result

// ==== sim/trr_ctrl_model.sv ====
// Purpose: Bus controller model reading the result register
// Assumes: Requests change 1 ns after the rising edge
// Notes:   Byte waits are bounded; ok low means a byte never came
`timescale 1ns/10ps
module trr_ctrl_model
    import trr_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic [BYTE_W-1:0] i_rd_byte,
    input  wire logic              i_byte_valid,
    output trr_bus_req_t           o_bus
);
    // Bus idle until a task runs
    initial begin
        o_bus = '0;
    end

    // Next drive point
    task automatic tick();
        @(posedge i_sys_clk);
        #1;
    endtask

    task automatic ptr_write(input logic [PTR_W-1:0] val);
        tick();
        o_bus.ptr_val = val;
        o_bus.ptr_wr  = 1'b1;
        tick();
        o_bus.ptr_wr  = 1'b0;
    endtask

    task automatic fetch(output logic [BYTE_W-1:0] b, inout logic ok);
        int n;
        tick();
        o_bus.byte_req = 1'b1;
        tick();
        o_bus.byte_req = 1'b0;
        for (n = 0; n < 3 && i_byte_valid !== 1'b1; n++) begin
            tick();
        end
        ok = ok & (i_byte_valid === 1'b1);
        b  = i_rd_byte;
    endtask

    // high byte, optional low, then end
    task automatic read(input int nb, output logic [BYTE_W-1:0] hi,
                        output logic [BYTE_W-1:0] lo, output logic ok);
        ok = 1'b1;
        lo = BYTE_IDLE;
        tick();
        o_bus.rd_start = 1'b1;
        tick();
        o_bus.rd_start = 1'b0;
        fetch(hi, ok);
        if (nb == 2) begin
            fetch(lo, ok);
        end
        tick();
        o_bus.xfer_end = 1'b1;
        tick();
        o_bus.xfer_end = 1'b0;
    endtask
endmodule // trr_ctrl_model

// ==== sim/temperature_result_register_tb_top.sv ====
// Purpose: Self-checking bench for the temperature result register
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected words are built here from the format rules
`timescale 1ns/10ps
module temperature_result_register_tb_top
    import trr_pkg::*;
();
    logic                sys_clk = 1'b0;
    logic                rst_n   = 1'b0;
    logic                sel     = 1'b0;
    trr_conv_t           conv    = '0;
    trr_bus_req_t        bus;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] exp_w;
    logic [BYTE_W-1:0]   rd_byte, hi, lo;
    logic                byte_valid, data_drive, temp_sel, conv_seen, ok;
    logic [RAW_W-1:0]    raws [6] = '{13'h0190, 13'h1e70, 13'h0960,
                                      13'h1000, 13'h1fff, 13'h0001};
    int                  n_fail   = 0;
    int                  n_checks = 0;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    trr_result u_dut (
        .i_sys_clk               (sys_clk),
        .i_rst_n                 (rst_n),
        .i_conv                  (conv),
        .i_extended_format_select(sel),
        .i_bus                   (bus),
        .o_temp_result           (result),
        .o_rd_byte               (rd_byte),
        .o_byte_valid            (byte_valid),
        .o_data_drive            (data_drive),
        .o_temp_sel              (temp_sel),
        .o_conv_seen             (conv_seen)
    );

    trr_ctrl_model u_ctrl (
        .i_sys_clk   (sys_clk),
        .i_rd_byte   (rd_byte),
        .i_byte_valid(byte_valid),
        .o_bus       (bus)
    );

    // Count and report one comparison
    task automatic note(input logic bad, input string m);
        n_checks++;
        if (bad) begin
            n_fail++;
            $display("ERROR %0t ns: %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [RESULT_W-1:0] g, e, input string m);
        note(g !== e, m);
    endtask

    task automatic chk_byte(input logic [BYTE_W-1:0] g, e, input string m);
        note(g !== e, m);
    endtask

    task automatic chk_bit(input logic g, e, input string m);
        note(g !== e, m);
    endtask

    // Normal format clamps, since 12 bits cannot hold the full raw range
    function automatic logic [RESULT_W-1:0] exp_word(
        input logic signed [RAW_W-1:0] raw, input logic ext);
        if (ext) return {raw, 2'b00, 1'b1};
        if (raw > 13'sh07ff) return 16'h7ff0;
        if (raw < -13'sh0800) return 16'h8000;
        return {raw[11:0], 4'h0};
    endfunction

    // One conversion pulse; select stays as a level
    task automatic convert(input logic [RAW_W-1:0] raw, input logic ext);
        @(posedge sys_clk);
        #1;
        conv = '{done: 1'b1, raw: raw};
        sel  = ext;
        @(posedge sys_clk);
        #1;
        conv.done = 1'b0;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    initial begin
        #1_000_000;
        note(1'b1, "run hung");
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk_word(result, RESULT_RST, "reset word");
        chk_bit(temp_sel, 1'b1, "reset pointer");
        u_ctrl.read(2, hi, lo, ok);
        chk_word({hi, lo}, RESULT_RST, "read before conversion");
        chk_bit(conv_seen, 1'b0, "no conversion yet");
        $display("test reset done");
        foreach (raws[i]) begin
            for (int x = 0; x < 2; x++) begin
                convert(raws[i], x[0]);
                exp_w = exp_word(raws[i], x[0]);
                chk_word(result, exp_w, "word");
                chk_bit(result[RESULT_W-1], raws[i][RAW_W-1], "sign");
                chk_bit(result[FMT_BIT], x[0], "format bit");
                u_ctrl.read(2, hi, lo, ok);
                chk_bit(ok, 1'b1, "both bytes arrived");
                chk_word({hi, lo}, exp_w, "bytes high then low");
                chk_bit(data_drive, 1'b0, "drive released");
            end
        end
        $display("test formats done");
        convert(13'h0320, 1'b0);
        u_ctrl.read(1, hi, lo, ok);
        chk_bit(ok, 1'b1, "short read byte came");
        chk_byte(hi, 8'h32, "short read high");
        chk_byte(rd_byte, BYTE_IDLE, "byte cleared at end");
        chk_bit(data_drive, 1'b0, "short read drive");
        u_ctrl.read(2, hi, lo, ok);
        chk_word({hi, lo}, 16'h3200, "read after short");
        $display("test short read done");
        u_ctrl.ptr_write(8'h01);
        chk_bit(temp_sel, 1'b0, "other pointer");
        u_ctrl.read(2, hi, lo, ok);
        chk_bit(ok, 1'b0, "other register read");
        chk_bit(data_drive, 1'b0, "no drive for other");
        u_ctrl.ptr_write(PTR_TEMP);
        u_ctrl.read(2, hi, lo, ok);
        chk_bit(ok, 1'b1, "pointer back read");
        chk_word({hi, lo}, 16'h3200, "pointer back word");
        $display("test pointer done");
        fork
            u_ctrl.read(2, hi, lo, ok);
            begin
                repeat (2) @(posedge sys_clk);
                convert(13'h1c90, 1'b1);
            end
            begin
                repeat (3) @(posedge sys_clk);
                #1;
                chk_bit(data_drive, 1'b1, "drive during read");
            end
        join
        chk_word({hi, lo}, 16'h3200, "read mixes conversions");
        chk_word(result, exp_word(13'h1c90, 1'b1), "late word");
        chk_bit(conv_seen, 1'b1, "conversion seen");
        $display("test atomic read done");
        // Reset again in mid-run, with another pointer selected
        u_ctrl.ptr_write(8'h01);
        @(posedge sys_clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk_word(result, RESULT_RST, "word after reset");
        chk_bit(conv_seen, 1'b0, "seen cleared by reset");
        chk_bit(temp_sel, 1'b1, "pointer after reset");
        u_ctrl.read(2, hi, lo, ok);
        chk_word({hi, lo}, RESULT_RST, "read after reset");
        $display("test mid reset done");
        print_verdict();
    end
endmodule // temperature_result_register_tb_top
